// ### verilog/fpc_control.v
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_control #(
	parameter LINES = `FPC_LINES // [RQ19]
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        progEvent,
	input  wire        secError,
	input  wire        dedError,
	input  wire        instrHit,
	input  wire        instrMiss,
	output reg  [2:0]  cacheOn,
	output reg  [2:0]  lineInvalidate,
	output reg         bufferInvalidate,
	output reg  [4:0]  totalWaits,
	output reg  [1:0]  predictiveFetchMode,
	output reg         busError,
	output reg         cacheIrq
);
	localparam ST_IDLE   = 3'b001;
	localparam ST_ACCESS = 3'b010;
	localparam ST_DONE   = 3'b100;

	reg  [2:0]  state;
	reg  [31:0] control;
	reg  [2:0]  flushBusy;
	reg  [2:0]  flushCount [0:2];
	reg  [7:0]  countdown;
	reg         secFlag;
	reg         dedFlag;
	reg  [31:0] hitTally;
	reg  [31:0] missTally;
	reg         perfLast;
	reg  [31:0] next_prdata;
	reg         next_err;
	wire        setup;
	wire        doWrite;
	wire        hitCtrl;
	wire        hitStat;
	wire [2:0]  cohBits;
	wire [2:0]  flushReq;
	wire        perfRise;

	assign setup    = psel && !penable;
	// write lands at the edge where the master samples pready high
	assign doWrite  = (state == ST_DONE) && psel && penable && pwrite;
	assign hitCtrl  = (paddr == `FPC_ADDR_CTRL);
	assign hitStat  = (paddr == `FPC_ADDR_STAT);
	assign cohBits  = {control[`FPC_B_PER_CO], control[`FPC_B_DAT_CO], control[`FPC_B_INS_CO]};
	// manual flush written this cycle, one bit per cache
	assign flushReq = (doWrite && hitCtrl) ?
		{pwdata[`FPC_B_PER_FL], pwdata[`FPC_B_DAT_FL], pwdata[`FPC_B_INS_FL]} : 3'h0;
	assign perfRise = control[`FPC_B_PERF] && !perfLast;

	// apb slave: one wait cycle, ready in the access cycle after
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					if (setup) begin
						state <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					pready <= 1'b1;
					pslverr <= next_err;
					prdata <= next_prdata;
					state <= ST_DONE;
				end
				ST_DONE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// read mux; unmapped addresses answer with slave error
	always @* begin
		next_prdata = 32'h0;
		next_err = 1'b0;
		case (paddr)
			`FPC_ADDR_CTRL: next_prdata = (control & `FPC_CTRL_MASK & ~`FPC_FLUSH_BITS) |
				{9'h0, flushBusy, 20'h0};
			`FPC_ADDR_STAT: next_prdata = {4'h0, dedFlag, secFlag, 18'h0, countdown}; // [RQ16]
			`FPC_ADDR_HIT: next_prdata = hitTally;
			`FPC_ADDR_MISS: next_prdata = missTally;
			default: next_err = 1'b1;
		endcase
	end

	// control register; flush bits live in flushBusy
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			control <= `FPC_CTRL_RESET;
			perfLast <= 1'b0;
		end else begin
			perfLast <= control[`FPC_B_PERF];
			if (doWrite && hitCtrl) begin
				control <= pwdata & `FPC_CTRL_MASK & ~`FPC_FLUSH_BITS;
			end
		end
	end

	// per-cache invalidation sequencers
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : inv
			always @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					flushBusy[gi] <= 1'b0;
					flushCount[gi] <= 3'h0;
				end else if (flushReq[gi] || (progEvent && cohBits[gi])) begin // [RQ2] [RQ4]
					flushBusy[gi] <= 1'b1;
					flushCount[gi] <= `FPC_INV_CYCLES;
				end else if (flushBusy[gi]) begin
					if (flushCount[gi] == 3'h1) begin
						flushBusy[gi] <= 1'b0; // [RQ2]
					end
					flushCount[gi] <= flushCount[gi] - 3'h1;
				end
			end
		end
	endgenerate

	// cache steering outputs toward datapath
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cacheOn <= 3'h0;
			lineInvalidate <= 3'h7;
			bufferInvalidate <= 1'b1;
			totalWaits <= 5'h0;
			predictiveFetchMode <= `FPC_PMODE_OFF;
		end else begin
			// disabled cache bypasses to flash and holds lines invalid
			cacheOn <= {control[`FPC_B_PER_ON], control[`FPC_B_DAT_ON],
				control[`FPC_B_INS_ON]}; // [RQ1] [RQ20]
			lineInvalidate <= flushBusy | ~{control[`FPC_B_PER_ON], control[`FPC_B_DAT_ON],
				control[`FPC_B_INS_ON]}; // [RQ1]
			bufferInvalidate <= flushBusy[0] || !control[`FPC_B_INS_ON]; // [RQ3]
			totalWaits <= {4'h0, control[`FPC_B_AWAIT]} +
				{1'b0, control[`FPC_F_WS_HI:`FPC_F_WS_LO]}; // [RQ7] [RQ8]
			// unsupported encodings fall back to off
			if (control[`FPC_F_PMODE_HI:`FPC_F_PMODE_LO] == `FPC_PMODE_CACHE) begin
				predictiveFetchMode <= `FPC_PMODE_CACHE; // [RQ9]
			end else begin
				predictiveFetchMode <= `FPC_PMODE_OFF;
			end
		end
	end

	// error status: hardware set wins over software write
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			countdown <= 8'h0;
			secFlag <= 1'b0;
			dedFlag <= 1'b0;
			busError <= 1'b0;
			cacheIrq <= 1'b0;
		end else begin
			if (doWrite && hitStat) begin
				countdown <= pwdata[`FPC_F_CNT_HI:`FPC_F_CNT_LO];
				secFlag <= pwdata[`FPC_B_SEC];
				dedFlag <= pwdata[`FPC_B_DED];
			end
			if (secError) begin // [RQ14]
				if (countdown != 8'h0) begin
					countdown <= countdown - 8'h1; // [RQ11]
				end else begin
					countdown <= 8'h0; // [RQ11]
					secFlag <= 1'b1; // [RQ12]
				end
			end
			if (dedError) begin
				dedFlag <= 1'b1; // [RQ15]
			end
			busError <= dedError; // [RQ15]
			cacheIrq <= secFlag && control[`FPC_B_IRQ_ON]; // [RQ10] [RQ13]
		end
	end

	// performance tallies, cleared on enable rising edge
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hitTally <= 32'h0;
			missTally <= 32'h0;
		end else if (perfRise) begin
			hitTally <= 32'h0; // [RQ6]
			missTally <= 32'h0; // [RQ6]
		end else if (control[`FPC_B_PERF]) begin
			if (instrHit) begin
				hitTally <= hitTally + 32'h1; // [RQ17]
			end
			if (instrMiss) begin
				missTally <= missTally + 32'h1; // [RQ18]
			end
		end
	end
endmodule
`default_nettype wire

// ### verilog/fpc_defs.vh
// Notes on behaviour
// RQ1: each cache enable off means no hits and all lines held invalid.
// RQ2: writing one to flush starts invalidation; reads one until hardware clears it.
// RQ3: instruction cache invalidation also empties the prefetch buffer.
// RQ4: auto-coherent bit set invalidates that cache on each flash programming event.
// RQ5: software fixes auto-coherent bits before starting flash programming.
// RQ6: perf enable gates counters; rising edge of enable clears both tallies.
// RQ7: extra address wait adds one wait; total is address plus access waits.
// RQ8: four-bit access wait field is a plain binary count zero to fifteen.
// RQ9: predictive fetch mode 00 off, 01 cacheable regions only, others unsupported.
// RQ10: corrected-error irq enable gates interrupt; flag sets regardless.
// RQ11: eight-bit countdown decrements per corrected error and holds at zero.
// RQ12: corrected error while countdown is zero sets corrected-error flag.
// RQ13: flag set with irq enable raises the interrupt event output.
// RQ14: every corrected error counts, repeats at one address included.
// RQ15: uncorrectable error sets its flag and answers the read with bus error.
// RQ16: status bits 25..8 and 31..28 read zero, writes ignored.
// RQ17: with counting on, hit tally increments per instruction or buffer hit.
// RQ18: with counting on, miss tally increments per instruction or buffer miss.
// RQ19: four lines of 32 bytes per cache, three caches.
// RQ20: disabled cache goes straight to flash with total waits, no allocation.
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
`define FPC_ADDR_CTRL     12'h000
`define FPC_ADDR_STAT     12'h010
`define FPC_ADDR_HIT      12'h020
`define FPC_ADDR_MISS     12'h030
`define FPC_CTRL_RESET    32'h07000107
`define FPC_CTRL_MASK     32'h077711bf
`define FPC_FLUSH_BITS    32'h00700000
`define FPC_STAT_MASK     32'h0c0000ff
`define FPC_B_PER_ON      26
`define FPC_B_DAT_ON      25
`define FPC_B_INS_ON      24
`define FPC_B_PER_FL      22
`define FPC_B_DAT_FL      21
`define FPC_B_INS_FL      20
`define FPC_B_PER_CO      18
`define FPC_B_DAT_CO      17
`define FPC_B_INS_CO      16
`define FPC_B_PERF        12
`define FPC_B_AWAIT       8
`define FPC_B_IRQ_ON      7
`define FPC_F_PMODE_HI    5
`define FPC_F_PMODE_LO    4
`define FPC_F_WS_HI       3
`define FPC_F_WS_LO       0
`define FPC_B_DED         27
`define FPC_B_SEC         26
`define FPC_F_CNT_HI      7
`define FPC_F_CNT_LO      0
`define FPC_PMODE_OFF     2'h0
`define FPC_PMODE_CACHE   2'h1
`define FPC_LINES         4
`define FPC_INV_CYCLES    3'h4
`endif

// ### bench/fpc_control_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_control_properties #(parameter LINES = 4) (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       dedError,
	input wire logic       busError,
	input wire logic [2:0] cacheOn,
	input wire logic [2:0] lineInvalidate,
	input wire logic       bufferInvalidate,
	input wire logic [1:0] predictiveFetchMode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_off_invalid: assert property ((~cacheOn & ~lineInvalidate) == 3'h0)
		else $error("disabled cache valid");
	a_flush_buffer: assert property (bufferInvalidate == lineInvalidate[0])
		else $error("buffer not with icache");
	a_ded_buserr: assert property (dedError |=> busError)
		else $error("no bus error");
	a_buserr_cause: assert property (busError |-> $past(dedError))
		else $error("stray bus error");
	a_mode_legal: assert property (!predictiveFetchMode[1])
		else $error("bad fetch mode");
	a_apb_answer: assert property (psel && !penable |-> ##2 pready)
		else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind fpc_control fpc_control_properties #(.LINES(LINES)) i_props (.clock(clock), .nrst(nrst),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .dedError(dedError),
	.busError(busError), .cacheOn(cacheOn), .lineInvalidate(lineInvalidate),
	.bufferInvalidate(bufferInvalidate), .predictiveFetchMode(predictiveFetchMode));
`default_nettype wire

// ### bench/fpc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model (
	input  wire logic       clock,
	input  wire logic [4:0] req,
	output var  logic       progEvent,
	output var  logic       secError,
	output var  logic       dedError,
	output var  logic       instrHit,
	output var  logic       instrMiss
);
	// idle lines low from time zero
	initial {progEvent, secError, dedError, instrHit, instrMiss} = 5'h00;
	// one pulse per request, repeats at one address allowed
	always @(posedge clock) begin
		{progEvent, secError, dedError, instrHit, instrMiss} <= req;
	end
endmodule
`default_nettype wire

// ### bench/fpc_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_control_tb_top;
	logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, progEvent, secError, dedError, instrHit, instrMiss;
	logic        busError, cacheIrq, bufferInvalidate;
	logic [2:0]  cacheOn, lineInvalidate;
	logic [4:0]  totalWaits, req = 5'h00;
	logic [1:0]  predictiveFetchMode;
	int          n_fail = 0, tests_run = 0;
	// system clock
	always #5 clock = ~clock;
	fpc_control i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .progEvent(progEvent), .secError(secError), .dedError(dedError),
		.instrHit(instrHit), .instrMiss(instrMiss), .cacheOn(cacheOn),
		.lineInvalidate(lineInvalidate), .bufferInvalidate(bufferInvalidate),
		.totalWaits(totalWaits), .predictiveFetchMode(predictiveFetchMode),
		.busError(busError), .cacheIrq(cacheIrq));
	fpc_flash_model i_flash (.clock(clock), .req(req), .progEvent(progEvent),
		.secError(secError), .dedError(dedError), .instrHit(instrHit), .instrMiss(instrMiss));
	task final_report;
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock) penable <= 1;
		@(posedge clock);
		for (k = 0; pready !== 1'b1 && k < 9; k++) @(posedge clock);
		chk(32'(pready), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
		@(posedge clock);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 32'h0);
		chk(r, x);
	endtask
	task pulse(input logic [4:0] m, input int k);
		repeat (k) begin
			req <= m;
			@(posedge clock);
			req <= 5'h00;
			@(posedge clock);
		end
	endtask
	// collect invalidate outputs over a few cycles
	task watch(input logic [3:0] x);
		logic [3:0] s;
		s = 4'h0;
		repeat (7) begin
			@(posedge clock);
			s = s | {bufferInvalidate, lineInvalidate};
		end
		chk(32'(s), 32'(x));
	endtask
	task t_regs;
		rd(12'h000, 32'h07000107);
		chk(32'(totalWaits), 32'd8);
		apb(0, 12'h040, 32'h0);
		chk(32'(e), 32'h1);
		wr(12'h000, 32'h0);
		chk(32'({cacheOn, lineInvalidate, bufferInvalidate, totalWaits}), 32'h1e0);
		wr(12'h000, 32'h0000010f);
		chk(32'(totalWaits), 32'd16);
		wr(12'h000, 32'h0000000f);
		chk(32'(totalWaits), 32'd15);
		for (int m = 0; m < 4; m++) begin
			wr(12'h000, 32'h07000107 | (m << 4));
			chk(32'(predictiveFetchMode), 32'(m == 1));
		end
	endtask
	task t_flush;
		wr(12'h000, 32'h07200107);
		watch(4'h2);
		wr(12'h000, 32'h07100107);
		watch(4'h9);
		rd(12'h000, 32'h07000107);
		wr(12'h000, 32'h07010107);
		pulse(5'h10, 1);
		watch(4'h9);
		wr(12'h000, 32'h07000107);
		pulse(5'h10, 1);
		watch(4'h0);
	endtask
	task t_perf;
		wr(12'h000, 32'h07001107);
		pulse(5'h02, 3);
		pulse(5'h01, 2);
		rd(12'h020, 32'd3);
		rd(12'h030, 32'd2);
		wr(12'h000, 32'h07000107);
		wr(12'h000, 32'h07001107);
		rd(12'h020, 32'd0);
		rd(12'h030, 32'd0);
	endtask
	task t_errors;
		wr(12'h010, 32'h3);
		wr(12'h000, 32'h07000187);
		pulse(5'h08, 2);
		rd(12'h010, 32'h1);
		pulse(5'h08, 2);
		rd(12'h010, 32'h04000000);
		chk(32'(cacheIrq), 32'h1);
		wr(12'h000, 32'h07000107);
		chk(32'(cacheIrq), 32'h0);
		pulse(5'h04, 1);
		rd(12'h010, 32'h0c000000);
		wr(12'h010, 32'hffffffff);
		rd(12'h010, 32'h0c0000ff);
	endtask
	// mid-run reset: outputs return to reset levels
	task t_reset;
		nrst <= 0;
		@(posedge clock);
		@(posedge clock);
		chk(32'({cacheOn, lineInvalidate, bufferInvalidate}), 32'h0f);
		nrst <= 1;
		@(posedge clock);
		@(posedge clock);
		chk(32'(cacheOn), 32'h7);
		rd(12'h010, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		nrst <= 1;
		@(posedge clock);
		t_regs;
		t_flush;
		t_perf;
		t_errors;
		t_reset;
		final_report;
	end
	// watchdog over about ten thousand cycles
	initial begin
		#100000;
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire
